/* core/ide_core.v */
// Instruction decode and execute core for a 14-bit instruction set.
// Assumes an asynchronous program memory and file read port on core_clk.
//
// What this block does
// RULE_01: Decrement file into destination, skip next when zero, one or two cycles.
// RULE_02: Increment file into destination, skip next when zero, no flags.
// RULE_03: Test file bit, skip next when clear, second cycle a no-operation.
// RULE_04: Test file bit, skip next when set, otherwise one cycle.
// RULE_05: Rotate file left through carry into destination, carry only.
// RULE_06: Rotate file right through carry into destination, carry only.
// RULE_07: OR work with file into destination, update zero.
// RULE_08: XOR work with file into destination, update zero.
// RULE_09: OR literal into work in one cycle, zero only.
// RULE_10: XOR literal into work, update zero.
// RULE_11: Literal minus work into work, update carry, digit carry, zero.
// RULE_12: Load literal into work, pop return address, two cycles.
// RULE_13: Return from subroutine via stack, two cycles, no flags.
// RULE_14: Return from interrupt via stack in two cycles.
// RULE_15: Enter standby, update timeout and power-down flags.
// RULE_16: Watchdog clear and standby both restart the watchdog count.
// RULE_17: Watchdog timeout clears the timeout flag.
// RULE_18: Timeout resets core normally, wakes it from standby.
// RULE_19: Taken skip or branch discards the fetched word, runs a no-operation.
// RULE_20: Decode four groups by top bits; all listed operations implemented.
// RULE_21: Destination bit zero selects work, one selects the file.
`timescale 1ns/100ps
`include "ide_regs.vh"

module ide_core #(
    parameter [19:0] WDT_TIMEOUT_CYCLES = `IDE_WDT_CYCLES
) (
    input  wire        core_clk,            // Core clock, 40 MHz
    input  wire        rst_b,               // Asynchronous reset, low active
    input  wire        clk_en,              // Freezes all state while low
    input  wire [13:0] instr_word,          // Word at prog_addr_r
    input  wire [7:0]  file_rd_data,        // File data at file_addr_r
    input  wire        wdt_enable,          // Watchdog enabled
    output reg  [12:0] prog_addr_r,         // Fetch address
    output reg  [6:0]  file_addr_r,         // File address being read
    output reg  [7:0]  file_wr_data_r,      // File write data
    output reg  [6:0]  file_wr_addr_r,      // File write address
    output reg         file_wr_en_r,        // File write strobe
    output reg  [7:0]  work_reg_r,          // Working register
    output reg         carry_flag_r,        // Carry flag
    output reg         digit_carry_flag_r,  // Digit carry flag
    output reg         zero_flag_r,         // Zero flag
    output reg         timeout_flag_b_r,    // Timeout flag, low after timeout
    output reg         power_down_flag_b_r, // Power-down flag, low in standby
    output reg         standby_r,           // Core halted in standby
    output reg         int_enable_r,        // Global interrupt enable
    output reg         wdt_reset_r          // Pulse on watchdog reset
);

    reg        rst_meta_r;
    reg        rst_sync_r;
    reg [13:0] ir_r;
    reg        ir_valid_r;
    reg [2:0]  sp_r;
    reg [12:0] stack_mem [0:7];

    wire       wdt_timeout;
    wire [1:0] grp  = ir_r[`IDE_GRP_HI:`IDE_GRP_LO];
    wire [3:0] op   = ir_r[`IDE_OP_HI:`IDE_OP_LO];
    wire       dbit = ir_r[`IDE_DEST_BIT];
    wire [2:0] bsel = ir_r[`IDE_BIT_HI:`IDE_BIT_LO];
    wire [7:0] lit  = ir_r[7:0];
    wire [2:0] sp_dec = sp_r - 3'h1;

    // Write lands one cycle late, so a back-to-back read is forwarded
    wire [7:0] fval = (file_wr_en_r && (file_wr_addr_r == file_addr_r)) ?
                      file_wr_data_r : file_rd_data;

    reg [7:0]  res;
    reg [9:0]  sum;
    reg        wr_w, wr_f, upd_z, upd_c, upd_dc, c_nxt, dc_nxt;
    reg        skip, jump, push, pop, sleep_go, wdt_clr, gie_set;
    reg [12:0] jump_addr;
    reg [7:0]  mask;

    // Returns {digit carry, carry, sum} of a + b + cin
    function [9:0] ide_add;
        input [7:0] a;
        input [7:0] b;
        input       cin;
        reg   [4:0] lo;
        reg   [8:0] full;
        begin
            lo      = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            full    = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            ide_add = {lo[4], full};
        end
    endfunction

    // True when the whole instruction word equals a fixed control word
    function ide_is_word;
        input [13:0] w;
        input [13:0] code;
        begin
            ide_is_word = (w == code);
        end
    endfunction

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else if (clk_en) begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // Execute stage
    always @* begin
        res       = 8'h00;
        sum       = 10'h000;
        wr_w      = 1'b0;
        wr_f      = 1'b0;
        upd_z     = 1'b0;
        upd_c     = 1'b0;
        upd_dc    = 1'b0;
        c_nxt     = carry_flag_r;
        dc_nxt    = digit_carry_flag_r;
        skip      = 1'b0;
        jump      = 1'b0;
        jump_addr = stack_mem[sp_dec];
        push      = 1'b0;
        pop       = 1'b0;
        sleep_go  = 1'b0;
        wdt_clr   = 1'b0;
        gie_set   = 1'b0;
        mask      = 8'h01 << bsel;
        // RULE_20: group decode
        if (ir_valid_r) begin
            case (grp)
                `IDE_GRP_BYTE: begin
                    upd_z = 1'b1;
                    // RULE_21: destination select
                    wr_w  = !dbit;
                    wr_f  = dbit;
                    case (op)
                        `IDE_OP_MISC: begin
                            upd_z = 1'b0;
                            wr_w  = 1'b0;
                            res   = work_reg_r;
                            if (ide_is_word(ir_r, `IDE_W_RETURN)) begin
                                // RULE_13: subroutine return
                                pop  = 1'b1;
                                jump = 1'b1;
                            end else if (ide_is_word(ir_r, `IDE_W_RETINT)) begin
                                // RULE_14: interrupt return
                                pop     = 1'b1;
                                jump    = 1'b1;
                                gie_set = 1'b1;
                            end else if (ide_is_word(ir_r, `IDE_W_SLEEP)) begin
                                // RULE_15: enter standby
                                sleep_go = 1'b1;
                                wdt_clr  = 1'b1;
                            end else if (ide_is_word(ir_r, `IDE_W_WATCHDOG_CLEAR_INSTRUCTION)) begin
                                // RULE_16: watchdog clear
                                wdt_clr = 1'b1;
                            end
                        end
                        `IDE_OP_CLR:   res = 8'h00;
                        `IDE_OP_SUBWF, `IDE_OP_ADDWF: begin
                            sum    = ide_add(fval, op[2] ? work_reg_r : ~work_reg_r, !op[2]);
                            res    = sum[7:0];
                            upd_c  = 1'b1;
                            upd_dc = 1'b1;
                        end
                        `IDE_OP_DECF:  res = fval - 8'h01;
                        // RULE_07: or work with file
                        `IDE_OP_OR_WORK_WITH_FILE: res = work_reg_r | fval;
                        `IDE_OP_ANDWF: res = work_reg_r & fval;
                        // RULE_08: xor work with file
                        `IDE_OP_XOR_WORK_WITH_FILE: res = work_reg_r ^ fval;
                        `IDE_OP_MOVF:  res = fval;
                        `IDE_OP_COMF:  res = ~fval;
                        `IDE_OP_INCF:  res = fval + 8'h01;
                        // RULE_01: decrement, skip on zero
                        // RULE_02: increment, skip on zero
                        `IDE_OP_DECSZ, `IDE_OP_INCSZ: begin
                            res   = op[2] ? fval + 8'h01 : fval - 8'h01;
                            upd_z = 1'b0;
                            skip  = (res == 8'h00);
                        end
                        // RULE_05: rotate left via carry
                        // RULE_06: rotate right via carry
                        `IDE_OP_RRC, `IDE_OP_RLC: begin
                            res   = op[0] ? {fval[6:0], carry_flag_r} : {carry_flag_r, fval[7:1]};
                            c_nxt = op[0] ? fval[7] : fval[0];
                            upd_c = 1'b1;
                            upd_z = 1'b0;
                        end
                        `IDE_OP_SWAPF: begin
                            res   = {fval[3:0], fval[7:4]};
                            upd_z = 1'b0;
                        end
                    endcase
                end
                `IDE_GRP_BIT: begin
                    res = fval;
                    case (ir_r[11:10])
                        `IDE_BIT_CLR, `IDE_BIT_SET: begin
                            res  = ir_r[10] ? (fval | mask) : (fval & ~mask);
                            wr_f = 1'b1;
                        end
                        // RULE_03: skip when bit clear
                        `IDE_BIT_TSC: skip = ((fval & mask) == 8'h00);
                        // RULE_04: skip when bit set
                        default:      skip = ((fval & mask) != 8'h00);
                    endcase
                end
                `IDE_GRP_JUMP: begin
                    jump      = 1'b1;
                    push      = !ir_r[11];
                    jump_addr = {2'h0, ir_r[10:0]};
                end
                default: begin
                    wr_w = 1'b1;
                    casez (op)
                        4'b00??: res = lit;
                        4'b01??: begin
                            // RULE_12: literal return
                            res  = lit;
                            pop  = 1'b1;
                            jump = 1'b1;
                        end
                        4'b1000: begin
                            // RULE_09: or literal
                            res   = lit | work_reg_r;
                            upd_z = 1'b1;
                        end
                        4'b1001: begin
                            res   = lit & work_reg_r;
                            upd_z = 1'b1;
                        end
                        4'b1010: begin
                            // RULE_10: xor literal
                            res   = lit ^ work_reg_r;
                            upd_z = 1'b1;
                        end
                        // RULE_11: literal minus work
                        4'b11??: begin
                            sum    = ide_add(lit, op[1] ? work_reg_r : ~work_reg_r, !op[1]);
                            res    = sum[7:0];
                            upd_z  = 1'b1;
                            upd_c  = 1'b1;
                            upd_dc = 1'b1;
                        end
                        // Unassigned literal code runs as a no-operation
                        default: wr_w = 1'b0;
                    endcase
                end
            endcase
            if (upd_c && !(op == `IDE_OP_RRC || op == `IDE_OP_RLC) ||
                upd_c && grp != `IDE_GRP_BYTE) begin
                c_nxt  = sum[8];
                dc_nxt = sum[9];
            end
        end
    end

    wire wdt_hit   = wdt_timeout && !standby_r;
    wire wake      = wdt_timeout && standby_r;
    wire run       = !standby_r && !wdt_hit;

    ide_wdt #(
        .TIMEOUT_CYCLES (WDT_TIMEOUT_CYCLES)
    ) u_wdt (
        .core_clk  (core_clk),
        .rst_n     (rst_sync_r),
        .clk_en    (clk_en),
        .enable    (wdt_enable),
        .clear     (wdt_clr && run),
        .timeout_r (wdt_timeout)
    );

    // Stack array has no reset; the pointer alone defines its state
    always @(posedge core_clk) begin
        if (clk_en && run && push) begin
            stack_mem[sp_r] <= prog_addr_r;
        end
    end

    always @(posedge core_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            prog_addr_r         <= `IDE_RST_PC;
            file_addr_r         <= 7'h00;
            file_wr_data_r      <= 8'h00;
            file_wr_addr_r      <= 7'h00;
            file_wr_en_r        <= 1'b0;
            work_reg_r          <= `IDE_RST_W;
            carry_flag_r        <= 1'b0;
            digit_carry_flag_r  <= 1'b0;
            zero_flag_r         <= 1'b0;
            timeout_flag_b_r    <= 1'b1;
            power_down_flag_b_r <= 1'b1;
            standby_r           <= 1'b0;
            int_enable_r        <= 1'b0;
            wdt_reset_r         <= 1'b0;
            ir_r                <= 14'h0000;
            ir_valid_r          <= 1'b0;
            sp_r                <= `IDE_RST_SP;
        end else if (clk_en) begin
            wdt_reset_r  <= wdt_hit;
            file_wr_en_r <= 1'b0;
            if (wdt_hit) begin
                // RULE_18: timeout resets core
                prog_addr_r         <= `IDE_RST_PC;
                ir_valid_r          <= 1'b0;
                standby_r           <= 1'b0;
                int_enable_r        <= 1'b0;
                sp_r                <= `IDE_RST_SP;
                // RULE_17: timeout clears flag
                timeout_flag_b_r    <= 1'b0;
                power_down_flag_b_r <= 1'b1;
            end else if (standby_r) begin
                // RULE_18: wake and resume
                if (wake) begin
                    standby_r        <= 1'b0;
                    timeout_flag_b_r <= 1'b0;
                end
            end else begin
                ir_r        <= instr_word;
                file_addr_r <= instr_word[`IDE_FADDR_HI:`IDE_FADDR_LO];
                // RULE_19: discard fetched word
                ir_valid_r  <= !(skip || jump);
                prog_addr_r <= jump ? jump_addr : prog_addr_r + 13'h0001;
                if (push) begin
                    sp_r <= sp_r + 3'h1;
                end else if (pop) begin
                    sp_r <= sp_dec;
                end
                if (wr_w) begin
                    work_reg_r <= res;
                end
                file_wr_en_r   <= wr_f;
                file_wr_data_r <= res;
                file_wr_addr_r <= file_addr_r;
                if (upd_z) begin
                    zero_flag_r <= (res == 8'h00);
                end
                if (upd_c) begin
                    carry_flag_r <= c_nxt;
                end
                if (upd_dc) begin
                    digit_carry_flag_r <= dc_nxt;
                end
                int_enable_r <= int_enable_r | gie_set;
                if (wdt_clr) begin
                    timeout_flag_b_r    <= 1'b1;
                    power_down_flag_b_r <= !sleep_go;
                end
                // RULE_15: halt in standby
                standby_r <= sleep_go;
            end
        end
    end

endmodule // ide_core

/* core/ide_regs.vh */
// Constants for the instruction decode and execute block: instruction
// fields, opcode encodings, reset values and watchdog timing.
// Assumes a single 40 MHz core clock and a 14-bit instruction word.
`ifndef IDE_REGS_VH
`define IDE_REGS_VH

// Instruction word fields
`define IDE_GRP_HI          13
`define IDE_GRP_LO          12
`define IDE_OP_HI           11
`define IDE_OP_LO           8
`define IDE_DEST_BIT        7
`define IDE_BIT_HI          9
`define IDE_BIT_LO          7
`define IDE_FADDR_HI        6
`define IDE_FADDR_LO        0

// Top-level groups
`define IDE_GRP_BYTE        2'h0
`define IDE_GRP_BIT         2'h1
`define IDE_GRP_JUMP        2'h2
`define IDE_GRP_LIT         2'h3

// Byte-oriented opcode nibbles
`define IDE_OP_MISC         4'h0
`define IDE_OP_CLR          4'h1
`define IDE_OP_SUBWF        4'h2
`define IDE_OP_DECF         4'h3
`define IDE_OP_OR_WORK_WITH_FILE        4'h4
`define IDE_OP_ANDWF        4'h5
`define IDE_OP_XOR_WORK_WITH_FILE        4'h6
`define IDE_OP_ADDWF        4'h7
`define IDE_OP_MOVF         4'h8
`define IDE_OP_COMF         4'h9
`define IDE_OP_INCF         4'ha
`define IDE_OP_DECSZ        4'hb
`define IDE_OP_RRC          4'hc
`define IDE_OP_RLC          4'hd
`define IDE_OP_SWAPF        4'he
`define IDE_OP_INCSZ        4'hf

// Bit-oriented sub-codes, bits 11:10
`define IDE_BIT_CLR         2'h0
`define IDE_BIT_SET         2'h1
`define IDE_BIT_TSC         2'h2
`define IDE_BIT_TSS         2'h3

// Fixed control words
`define IDE_W_RETURN        14'h0008
`define IDE_W_RETINT        14'h0009
`define IDE_W_SLEEP         14'h0063
`define IDE_W_WATCHDOG_CLEAR_INSTRUCTION        14'h0064

// Reset values
`define IDE_RST_PC          13'h0000
`define IDE_RST_W           8'h00
`define IDE_RST_SP          3'h0

// Watchdog timing
`define IDE_CLK_KHZ         20'h09c40
`define IDE_WDT_PERIOD_MS   20'h00012
`define IDE_WDT_CYCLES      (`IDE_WDT_PERIOD_MS * `IDE_CLK_KHZ)

`endif

/* core/ide_wdt.v */
// Watchdog counter for the instruction decode and execute block.
// Assumes clear is a one-cycle pulse on core_clk; timeout is a pulse.
`timescale 1ns/100ps
`include "ide_regs.vh"

module ide_wdt #(
    parameter [19:0] TIMEOUT_CYCLES = `IDE_WDT_CYCLES
) (
    input  wire        core_clk,    // Core clock
    input  wire        rst_n,       // Synchronised reset, low active
    input  wire        clk_en,      // Freezes the count while low
    input  wire        enable,      // Watchdog enabled
    input  wire        clear,       // Restart the count
    output reg         timeout_r    // One-cycle timeout pulse
);

    reg [19:0] count_r;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r   <= 20'h00000;
            timeout_r <= 1'b0;
        end else if (clk_en) begin
            timeout_r <= 1'b0;
            // RULE_16: restart count
            if (clear || !enable) begin
                count_r <= 20'h00000;
            end else if (count_r == TIMEOUT_CYCLES - 20'h00001) begin
                count_r   <= 20'h00000;
                timeout_r <= 1'b1;
            end else begin
                count_r <= count_r + 20'h00001;
            end
        end
    end

endmodule // ide_wdt

/* dv/ide_core_bench.sv */
// Self-checking bench for ide_core with program and file models.
// Assumes a short watchdog count so timeouts come within a few dozen cycles.
`timescale 1ns/100ps
`include "ide_regs.vh"
module ide_core_bench;
    logic        core_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        clk_en = 1'b1;
    logic        wdt_enable = 1'b0;
    wire  [13:0] instr_word;
    wire  [7:0]  file_rd_data, file_wr_data_r, work_reg_r;
    wire  [12:0] prog_addr_r;
    wire  [6:0]  file_addr_r, file_wr_addr_r;
    wire         file_wr_en_r, carry_flag_r, digit_carry_flag_r, zero_flag_r;
    wire         timeout_flag_b_r, power_down_flag_b_r, standby_r, int_enable_r, wdt_reset_r;
    int          miscompares = 0;
    int          checks_done = 0;
    int          n;

    ide_core #(.WDT_TIMEOUT_CYCLES(20'h00032)) ide_core_inst (.core_clk, .rst_b, .clk_en,
        .instr_word, .file_rd_data, .wdt_enable, .prog_addr_r, .file_addr_r, .file_wr_data_r,
        .file_wr_addr_r, .file_wr_en_r, .work_reg_r, .carry_flag_r, .digit_carry_flag_r,
        .zero_flag_r, .timeout_flag_b_r, .power_down_flag_b_r, .standby_r, .int_enable_r,
        .wdt_reset_r);
    ide_mem_model ide_mem_model_inst (.core_clk, .prog_addr(prog_addr_r), .rd_addr(file_addr_r),
        .wr_data(file_wr_data_r), .wr_addr(file_wr_addr_r), .wr_en(file_wr_en_r),
        .word(instr_word), .rd_data(file_rd_data));

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic test_done;
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask

    // Blank program space, load words from base, reset, then run
    task automatic run(input int base, input logic [13:0] w [$], input int cycles);
        for (int i = 0; i < 32; i++) ide_mem_model_inst.rom[i] = 14'h0000;
        foreach (w[i]) ide_mem_model_inst.rom[base + i] = w[i];
        rst_b = 1'b0;
        repeat (10) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (cycles) @(negedge core_clk);
    endtask

    // Bounded wait: 0 for wake, 1 for watchdog reset
    task automatic await(input int sel);
        for (int i = 0; i < 200; i++) begin
            if (sel == 0 ? standby_r === 1'b0 : wdt_reset_r === 1'b1) return;
            @(negedge core_clk);
        end
        miscompares++;
        test_done;
    endtask

    task automatic logic_ops;
        ide_mem_model_inst.regs[32] = 8'h0f;
        ide_mem_model_inst.regs[33] = 8'hf0;
        run(0, '{14'h3035, 14'h04a0, 14'h0621, 14'h3802, 14'h3ac7, 14'h3c10, 14'h3c05,
            14'h2807}, 20);
        check(work_reg_r, 8'hf5);
        check({7'h0, carry_flag_r}, 8'h00);
        check({7'h0, digit_carry_flag_r}, 8'h01);
        check({7'h0, zero_flag_r}, 8'h00);
        check(ide_mem_model_inst.regs[32], 8'h3f);
        check(ide_mem_model_inst.regs[33], 8'hf0);
    endtask

    task automatic skips;
        ide_mem_model_inst.regs[48] = 8'h01;
        ide_mem_model_inst.regs[49] = 8'hff;
        ide_mem_model_inst.regs[50] = 8'h04;
        run(0, '{14'h0bb0, 14'h3011, 14'h0f31, 14'h3022, 14'h1932, 14'h3840, 14'h1d32,
            14'h3801, 14'h1832, 14'h3802, 14'h1c32, 14'h3808, 14'h280c}, 8);
        // Pause mid-program; results must not change
        clk_en = 1'b0;
        repeat (5) @(negedge core_clk);
        clk_en = 1'b1;
        repeat (25) @(negedge core_clk);
        check(work_reg_r, 8'h48);
        check(ide_mem_model_inst.regs[48], 8'h00);
        check(ide_mem_model_inst.regs[49], 8'hff);
    endtask

    task automatic calls;
        ide_mem_model_inst.regs[64] = 8'h81;
        run(16, '{14'h345a, 14'h380f, `IDE_W_RETURN, 14'h380f, `IDE_W_RETINT, 14'h380f}, 0);
        ide_mem_model_inst.rom[0] = 14'h0dc0;
        ide_mem_model_inst.rom[1] = 14'h0c40;
        ide_mem_model_inst.rom[2] = 14'h2010;
        ide_mem_model_inst.rom[3] = 14'h2012;
        ide_mem_model_inst.rom[4] = 14'h2014;
        ide_mem_model_inst.rom[5] = 14'h2805;
        repeat (30) @(negedge core_clk);
        check(ide_mem_model_inst.regs[64], 8'h02);
        check({7'h0, carry_flag_r}, 8'h00);
        check(work_reg_r, 8'h5a);
        check({7'h0, int_enable_r}, 8'h01);
    endtask

    task automatic sleep_wake;
        wdt_enable = 1'b1;
        run(0, '{14'h3001, `IDE_W_SLEEP, 14'h3880, 14'h2803}, 8);
        check({7'h0, standby_r}, 8'h01);
        check({7'h0, power_down_flag_b_r}, 8'h00);
        await(0);
        check({7'h0, timeout_flag_b_r}, 8'h00);
        repeat (4) @(negedge core_clk);
        check(work_reg_r, 8'h81);
        await(1);
        check(prog_addr_r[7:0], 8'h00);
    endtask

    task automatic wdt_clear;
        run(0, '{`IDE_W_WATCHDOG_CLEAR_INSTRUCTION, 14'h2800}, 5);
        n = 0;
        repeat (150) begin
            @(negedge core_clk);
            n += wdt_reset_r;
        end
        check(n[7:0], 8'h00);
        ide_mem_model_inst.rom[0] = 14'h0000;
        await(1);
        check({7'h0, timeout_flag_b_r}, 8'h00);
        wdt_enable = 1'b0;
    endtask

    initial begin
        logic_ops;
        skips;
        calls;
        sleep_wake;
        wdt_clear;
        test_done;
    end
endmodule // ide_core_bench

/* dv/ide_core_monitor.sv */
// Port checker for ide_core.
// Assumes a single clock domain and rst_b as the only reset.
`timescale 1ns/100ps
module ide_core_monitor (
    input wire        core_clk,            // Core clock
    input wire        rst_b,               // Reset, low active
    input wire        clk_en,              // Run enable
    input wire [13:0] instr_word,          // Fetched word
    input wire [12:0] prog_addr_r,         // Fetch address
    input wire [6:0]  file_addr_r,         // File read address
    input wire [7:0]  work_reg_r,          // Working register
    input wire        timeout_flag_b_r,    // Timeout flag, low active
    input wire        power_down_flag_b_r, // Power-down flag, low active
    input wire        standby_r,           // Standby
    input wire        int_enable_r,        // Interrupt enable
    input wire        wdt_reset_r          // Watchdog reset pulse
);
    logic [6:0] fetched_f_r;
    always @(posedge core_clk) begin
        fetched_f_r <= instr_word[6:0];
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sleep_hold_a: assert property (standby_r && $past(standby_r) |-> $stable(prog_addr_r))
        else $error("fetch address moved in standby");
    sleep_flags_a: assert property ($rose(standby_r) |-> !power_down_flag_b_r && timeout_flag_b_r)
        else $error("standby entry flags wrong");
    wake_flags_a: assert property ($fell(standby_r) |-> !timeout_flag_b_r && !wdt_reset_r)
        else $error("wake flags wrong");
    wdt_reset_state_a: assert property (wdt_reset_r |-> !timeout_flag_b_r && power_down_flag_b_r
        && prog_addr_r == 13'h0000 && !int_enable_r)
        else $error("watchdog reset state wrong");
    wdt_pulse_a: assert property (wdt_reset_r && clk_en |=> !wdt_reset_r)
        else $error("watchdog reset pulse too long");
    sleep_no_reset_a: assert property (standby_r && clk_en |=> !wdt_reset_r)
        else $error("reset instead of wake");
    fetch_field_a: assert property (clk_en && !standby_r && prog_addr_r != 13'h0000
        |=> standby_r || wdt_reset_r || file_addr_r == fetched_f_r)
        else $error("file address not from fetched word");
    freeze_a: assert property (!clk_en |=> $stable(prog_addr_r) && $stable(work_reg_r))
        else $error("state moved while frozen");
    cover property ($rose(standby_r));
    cover property ($fell(standby_r));
    cover property (wdt_reset_r);
endmodule // ide_core_monitor

bind ide_core ide_core_monitor ide_core_monitor_inst (.core_clk, .rst_b, .clk_en, .instr_word,
    .prog_addr_r, .file_addr_r, .work_reg_r, .timeout_flag_b_r, .power_down_flag_b_r,
    .standby_r, .int_enable_r, .wdt_reset_r);

/* dv/ide_mem_model.sv */
// Program memory and file register model beside ide_core.
// Assumes combinational reads; writes land on core_clk with the strobe high.
`timescale 1ns/100ps
module ide_mem_model (
    input  wire        core_clk,  // Core clock
    input  wire [12:0] prog_addr, // Fetch address
    input  wire [6:0]  rd_addr,   // File read address
    input  wire [7:0]  wr_data,   // File write data
    input  wire [6:0]  wr_addr,   // File write address
    input  wire        wr_en,     // File write strobe
    output wire [13:0] word,      // Fetched word
    output wire [7:0]  rd_data    // File read data
);
    // Small program space; tests stay below address 32
    logic [13:0] rom [0:31];
    logic [7:0]  regs [0:127];
    assign word = rom[prog_addr[4:0]];
    assign rd_data = regs[rd_addr];
    always @(posedge core_clk) begin
        if (wr_en) begin
            regs[wr_addr] <= wr_data;
        end
    end
endmodule // ide_mem_model
